// ---- core/can_flag_and_tx_handshake.sv ----
// CAN controller status flags, interrupt enables and transmit buffer handshake.
`timescale 1ns/1ps
`default_nettype none

module can_flag_and_tx_handshake
    import can_flag_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Register port.
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Error counters and bus events from the protocol engine.
    input wire logic [7:0] rx_error_count,
    input wire logic [8:0] tx_error_count,
    input wire logic recessive_run_seen,
    input wire logic sleep_mode,
    input wire logic bus_activity,
    // Receive path.
    input wire logic rx_overrun,
    input wire logic rx_msg_ready,
    output logic rx_swap,
    // Transmit path.
    input wire logic [2:0] tx_sent_ok,
    input wire logic [2:0] tx_active,
    output logic [2:0] tx_buffer_empty,
    output logic [2:0] abort_request,
    output logic bus_off_state,
    // Interrupt requests.
    output logic wake_irq,
    output logic error_irq,
    output logic rx_irq,
    output logic tx_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic in_range(
        input logic [8:0] value,
        input logic [8:0] lo,
        input logic [8:0] hi
    );
        begin
            in_range = (value >= lo) && (value <= hi);
        end
    endfunction

    // Write-one-clear with set priority and a hold while the cause persists.
    function automatic logic sticky(
        input logic cur,
        input logic set,
        input logic clr,
        input logic cause
    );
        begin
            sticky = set | (cur & ~(clr & ~cause));
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State.

    state_t s_r;
    state_t s_nxt;

    logic [8:0] rec_wide;
    logic wr_mode;
    logic wr_rx_flag;
    logic wr_rx_ie;
    logic wr_tx_flag;
    logic wr_tx_ctrl;

    assign rec_wide = {1'b0, rx_error_count};
    assign wr_mode = reg_write && (reg_addr == OFF_MODE_CONTROL);
    assign wr_rx_flag = reg_write && (reg_addr == OFF_RX_FLAG_STATUS);
    assign wr_rx_ie = reg_write && (reg_addr == OFF_RX_IRQ_ENABLE);
    assign wr_tx_flag = reg_write && (reg_addr == OFF_TX_FLAG_STATUS);
    assign wr_tx_ctrl = reg_write && (reg_addr == OFF_TX_ABORT_CONTROL);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        rx_bits_t set_c;
        rx_bits_t clr_c;
        rx_bits_t cause_c;
        logic [2:0] txe_set;
        logic [2:0] txe_clr;
        logic [2:0] abort_grant;
        logic [2:0] tx_empty_cur;
        s_nxt = s_r;
        set_c = '0;
        clr_c = '0;
        cause_c = '0;
        txe_set = '0;
        txe_clr = '0;
        abort_grant = '0;
        tx_empty_cur = s_r.tx_flags.tx_buffer_empty;
        s_nxt.swap = 1'b0;

        if (wr_mode) begin
            s_nxt.soft_reset_bit = reg_wdata[SOFT_RESET_POS];
        end

        // Bus-off entry and recovery.
        if (!s_r.bus_off_state) begin
            if (tx_error_count > BUS_OFF_LIMIT) begin
                s_nxt.bus_off_state = 1'b1;
                s_nxt.recovery_cnt = '0;
            end
        end else if (recessive_run_seen) begin
            if (s_r.recovery_cnt == RECOVERY_COUNT - 8'h01) begin
                s_nxt.bus_off_state = 1'b0;
                s_nxt.recovery_cnt = '0;
            end else begin
                s_nxt.recovery_cnt = s_r.recovery_cnt + 8'h01;
            end
        end

        // Receiver flag causes.
        cause_c.bus_off = s_nxt.bus_off_state;
        cause_c.rx_passive = in_range(rec_wide, PASSIVE_LO, PASSIVE_HI)
            && !s_r.rx_flags.bus_off;
        cause_c.tx_passive = in_range(tx_error_count, PASSIVE_LO, PASSIVE_HI)
            && !s_r.rx_flags.bus_off;
        cause_c.rx_warning = in_range(rec_wide, WARN_LO, WARN_HI)
            && !s_r.rx_flags.rx_passive
            && !s_r.rx_flags.tx_passive
            && !s_r.rx_flags.bus_off;
        cause_c.tx_warning = in_range(tx_error_count, WARN_LO, WARN_HI)
            && !s_r.rx_flags.rx_passive
            && !s_r.rx_flags.tx_passive
            && !s_r.rx_flags.bus_off;
        cause_c.wake = sleep_mode && bus_activity;
        cause_c.overrun = rx_overrun;

        // Foreground swap is blocked while the buffer is still full.
        if (rx_msg_ready && !s_r.rx_flags.receive_full && !s_r.soft_reset_bit) begin
            s_nxt.swap = 1'b1;
            cause_c.receive_full = 1'b1;
        end

        set_c = cause_c;
        if (wr_rx_flag) begin
            clr_c = rx_bits_t'(reg_wdata);
        end
        s_nxt.rx_flags.wake = sticky(s_r.rx_flags.wake, set_c.wake,
            clr_c.wake, cause_c.wake);
        s_nxt.rx_flags.rx_warning = sticky(s_r.rx_flags.rx_warning,
            set_c.rx_warning, clr_c.rx_warning, cause_c.rx_warning);
        s_nxt.rx_flags.tx_warning = sticky(s_r.rx_flags.tx_warning,
            set_c.tx_warning, clr_c.tx_warning, cause_c.tx_warning);
        s_nxt.rx_flags.rx_passive = sticky(s_r.rx_flags.rx_passive,
            set_c.rx_passive, clr_c.rx_passive, cause_c.rx_passive);
        s_nxt.rx_flags.tx_passive = sticky(s_r.rx_flags.tx_passive,
            set_c.tx_passive, clr_c.tx_passive, cause_c.tx_passive);
        s_nxt.rx_flags.bus_off = sticky(s_r.rx_flags.bus_off,
            set_c.bus_off, clr_c.bus_off, cause_c.bus_off);
        s_nxt.rx_flags.overrun = sticky(s_r.rx_flags.overrun,
            set_c.overrun, clr_c.overrun, cause_c.overrun);
        s_nxt.rx_flags.receive_full = sticky(s_r.rx_flags.receive_full,
            set_c.receive_full, clr_c.receive_full,
            cause_c.receive_full);

        if (wr_rx_ie) begin
            s_nxt.rx_enable = rx_bits_t'(reg_wdata);
        end

        // Transmit handshake.
        abort_grant = s_r.tx_ctrl.abort_request & ~tx_empty_cur
            & ~tx_active;
        txe_set = tx_sent_ok | abort_grant;
        if (wr_tx_flag) begin
            txe_clr = reg_wdata[TX_LOW_LSB +: 3];
        end
        s_nxt.tx_flags.tx_buffer_empty = txe_set
            | (tx_empty_cur & ~txe_clr);
        s_nxt.tx_flags.abort_acknowledge = abort_grant
            | (s_r.tx_flags.abort_acknowledge
            & ~(txe_clr & tx_empty_cur & ~txe_set));
        if (wr_tx_ctrl) begin
            s_nxt.tx_ctrl.tx_empty_irq_enable = reg_wdata[TX_LOW_LSB +: 3];
            s_nxt.tx_ctrl.abort_request = s_r.tx_ctrl.abort_request
                | reg_wdata[TX_HIGH_LSB +: 3];
        end
        s_nxt.tx_ctrl.abort_request = s_nxt.tx_ctrl.abort_request
            & ~s_nxt.tx_flags.tx_buffer_empty;

        // Soft reset holds the four registers at their reset values.
        if (s_nxt.soft_reset_bit) begin
            s_nxt.rx_flags = rx_bits_t'(RX_FLAG_RESET);
            s_nxt.rx_enable = rx_bits_t'(RX_IE_RESET);
            s_nxt.tx_flags.tx_buffer_empty = TXE_RESET;
            s_nxt.tx_flags.abort_acknowledge = ABORT_ACKNOWLEDGE_RESET;
            s_nxt.tx_ctrl.abort_request = ABORT_REQUEST_RESET;
            s_nxt.tx_ctrl.tx_empty_irq_enable = TX_EMPTY_IRQ_ENABLE_RESET;
        end

        // Interrupt levels follow the flags of the same edge.
        s_nxt.irq.wake = s_nxt.rx_flags.wake & s_nxt.rx_enable.wake;
        s_nxt.irq.error = |({s_nxt.rx_flags.rx_warning, s_nxt.rx_flags.tx_warning,
            s_nxt.rx_flags.rx_passive, s_nxt.rx_flags.tx_passive,
            s_nxt.rx_flags.bus_off, s_nxt.rx_flags.overrun}
            & {s_nxt.rx_enable.rx_warning, s_nxt.rx_enable.tx_warning,
            s_nxt.rx_enable.rx_passive, s_nxt.rx_enable.tx_passive,
            s_nxt.rx_enable.bus_off, s_nxt.rx_enable.overrun});
        s_nxt.irq.receive = s_nxt.rx_flags.receive_full
            & s_nxt.rx_enable.receive_full;
        s_nxt.irq.transmit = |(s_nxt.tx_flags.tx_buffer_empty
            & s_nxt.tx_ctrl.tx_empty_irq_enable);

        // Read data shows the registers as they stand before this edge.
        s_nxt.rdata = '0;
        if (reg_read) begin
            case (reg_addr)
                OFF_MODE_CONTROL: begin
                    s_nxt.rdata[SOFT_RESET_POS] = s_r.soft_reset_bit;
                end
                OFF_RX_FLAG_STATUS: begin
                    s_nxt.rdata = s_r.rx_flags;
                end
                OFF_RX_IRQ_ENABLE: begin
                    s_nxt.rdata = s_r.rx_enable;
                end
                OFF_TX_FLAG_STATUS: begin
                    s_nxt.rdata[TX_HIGH_LSB +: 3] = s_r.tx_flags.abort_acknowledge;
                    s_nxt.rdata[TX_LOW_LSB +: 3] = s_r.tx_flags.tx_buffer_empty;
                end
                OFF_TX_ABORT_CONTROL: begin
                    s_nxt.rdata[TX_HIGH_LSB +: 3] = s_r.tx_ctrl.abort_request;
                    s_nxt.rdata[TX_LOW_LSB +: 3] = s_r.tx_ctrl.tx_empty_irq_enable;
                end
                OFF_BUS_STATE: begin
                    s_nxt.rdata[SOFT_RESET_POS] = s_r.bus_off_state;
                end
                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_r.rx_flags <= rx_bits_t'(RX_FLAG_RESET);
            s_r.rx_enable <= rx_bits_t'(RX_IE_RESET);
            s_r.tx_flags.tx_buffer_empty <= TXE_RESET;
            s_r.tx_flags.abort_acknowledge <= ABORT_ACKNOWLEDGE_RESET;
            s_r.tx_ctrl.abort_request <= ABORT_REQUEST_RESET;
            s_r.tx_ctrl.tx_empty_irq_enable <= TX_EMPTY_IRQ_ENABLE_RESET;
            s_r.soft_reset_bit <= MODE_RESET;
            s_r.bus_off_state <= 1'b0;
            s_r.recovery_cnt <= '0;
            s_r.swap <= 1'b0;
            s_r.irq <= '0;
            s_r.rdata <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reg_rdata = s_r.rdata;
    assign rx_swap = s_r.swap;
    assign tx_buffer_empty = s_r.tx_flags.tx_buffer_empty;
    assign abort_request = s_r.tx_ctrl.abort_request;
    assign bus_off_state = s_r.bus_off_state;
    assign wake_irq = s_r.irq.wake;
    assign error_irq = s_r.irq.error;
    assign rx_irq = s_r.irq.receive;
    assign tx_irq = s_r.irq.transmit;

endmodule

`default_nettype wire

// ---- core/can_flag_pkg.sv ----
// Package with register map, field layouts and thresholds for the CAN flag block.
package can_flag_pkg;

    // Register offsets.
    localparam logic [8:0] OFF_MODE_CONTROL = 9'h100;
    localparam logic [8:0] OFF_RX_FLAG_STATUS = 9'h104;
    localparam logic [8:0] OFF_RX_IRQ_ENABLE = 9'h105;
    localparam logic [8:0] OFF_TX_FLAG_STATUS = 9'h106;
    localparam logic [8:0] OFF_TX_ABORT_CONTROL = 9'h107;
    localparam logic [8:0] OFF_BUS_STATE = 9'h108;

    // Field positions inside the transmit, mode and bus state registers.
    localparam int TX_LOW_LSB = 0;
    localparam int TX_HIGH_LSB = 4;
    localparam int SOFT_RESET_POS = 0;

    // Reset values.
    localparam logic [7:0] RX_FLAG_RESET = 8'h00;
    localparam logic [7:0] RX_IE_RESET = 8'h00;
    localparam logic [2:0] TXE_RESET = 3'h7;
    localparam logic [2:0] ABORT_ACKNOWLEDGE_RESET = 3'h0;
    localparam logic [2:0] ABORT_REQUEST_RESET = 3'h0;
    localparam logic [2:0] TX_EMPTY_IRQ_ENABLE_RESET = 3'h0;
    localparam logic MODE_RESET = 1'b0;

    // Error counter thresholds.
    localparam logic [8:0] WARN_LO = 9'h060;
    localparam logic [8:0] WARN_HI = 9'h07F;
    localparam logic [8:0] PASSIVE_LO = 9'h080;
    localparam logic [8:0] PASSIVE_HI = 9'h0FF;
    localparam logic [8:0] BUS_OFF_LIMIT = 9'h0FF;

    // Number of 11-recessive-bit sequences needed to leave bus-off.
    localparam logic [7:0] RECOVERY_COUNT = 8'h80;

    typedef struct packed {
        logic wake;
        logic rx_warning;
        logic tx_warning;
        logic rx_passive;
        logic tx_passive;
        logic bus_off;
        logic overrun;
        logic receive_full;
    } rx_bits_t;

    typedef struct packed {
        logic [2:0] abort_acknowledge;
        logic [2:0] tx_buffer_empty;
    } tx_flags_t;

    typedef struct packed {
        logic [2:0] abort_request;
        logic [2:0] tx_empty_irq_enable;
    } tx_ctrl_t;

    typedef struct packed {
        logic wake;
        logic error;
        logic receive;
        logic transmit;
    } irq_t;

    typedef struct packed {
        rx_bits_t rx_flags;
        rx_bits_t rx_enable;
        tx_flags_t tx_flags;
        tx_ctrl_t tx_ctrl;
        logic soft_reset_bit;
        logic bus_off_state;
        logic [7:0] recovery_cnt;
        logic swap;
        irq_t irq;
        logic [7:0] rdata;
    } state_t;

endpackage

// ---- tb/can_flag_chk.sv ----
// Port-level checks for the CAN flag and transmit handshake block.
`timescale 1ns/1ps
`default_nettype none
module can_flag_chk
    import can_flag_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Inputs of the block.
    input wire logic reg_write,
    input wire logic [8:0] tx_error_count,
    input wire logic recessive_run_seen,
    input wire logic rx_msg_ready,
    input wire logic [2:0] tx_sent_ok,
    input wire logic [2:0] tx_active,
    // Outputs of the block.
    input wire logic rx_swap,
    input wire logic [2:0] tx_buffer_empty,
    input wire logic [2:0] abort_request,
    input wire logic bus_off_state,
    input wire logic tx_irq
);
    // Recessive runs seen since bus-off was entered.
    logic [7:0] runs_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            runs_r <= 8'h00;
        end else begin
            runs_r <= bus_off_state ? runs_r + 8'(recessive_run_seen) : 8'h00;
        end
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_enter; tx_error_count > BUS_OFF_LIMIT |=> bus_off_state; endproperty
    a_enter: assert property (p_enter) else $error("bus-off not entered");
    property p_exit; $fell(bus_off_state) |-> runs_r == RECOVERY_COUNT; endproperty
    a_exit: assert property (p_exit) else $error("bus-off left early");
    property p_swap; rx_swap |-> $past(rx_msg_ready) ##1 !rx_swap; endproperty
    a_swap: assert property (p_swap) else $error("bad swap");
    property p_grant; abort_request[0] && !tx_active[0] |=> tx_buffer_empty[0]; endproperty
    a_grant: assert property (p_grant) else $error("abort not granted");
    property p_block; tx_active[0] && !tx_buffer_empty[0] && !tx_sent_ok[0] && !reg_write
        |=> !tx_buffer_empty[0]; endproperty
    a_block: assert property (p_block) else $error("active buffer released");
    property p_clear; (tx_buffer_empty & abort_request) == 3'h0; endproperty
    a_clear: assert property (p_clear) else $error("abort kept on empty");
    property p_sent; tx_sent_ok[0] |=> tx_buffer_empty[0]; endproperty
    a_sent: assert property (p_sent) else $error("empty not set");
    property p_irq; tx_buffer_empty == 3'h0 |-> !tx_irq; endproperty
    a_irq: assert property (p_irq) else $error("transmit irq without empty");
endmodule
`default_nettype wire

// ---- tb/can_engine_model.sv ----
// Behavioural protocol engine that sends, fails and idles on command.
`timescale 1ns/1ps
`default_nettype none
module can_engine_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Commands from the test sequence.
    input wire logic [2:0] start,
    input wire logic [2:0] finish,
    input wire logic [2:0] fail,
    input wire logic bus_idle,
    // Device side.
    input wire logic [2:0] tx_buffer_empty,
    output logic [2:0] tx_active,
    output logic [2:0] tx_sent_ok,
    output logic recessive_run_seen
);
    logic [3:0] bits_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_active <= 3'h0;
            tx_sent_ok <= 3'h0;
            recessive_run_seen <= 1'b0;
            bits_r <= 4'h0;
        end else begin
            // Only a scheduled buffer is sent; a failed attempt becomes abortable.
            tx_active <= (tx_active | start) & ~tx_buffer_empty & ~finish & ~fail;
            tx_sent_ok <= finish & tx_active;
            // One pulse per 11 recessive bit times, one bit per clock.
            bits_r <= (!bus_idle || bits_r == 4'hA) ? 4'h0 : bits_r + 4'h1;
            recessive_run_seen <= bus_idle && bits_r == 4'hA;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_can_flag_and_tx_handshake.sv ----
// Self-checking testbench for the CAN flag and transmit handshake block.
`timescale 1ns/1ps
`default_nettype none
module tb_can_flag_and_tx_handshake;
    localparam logic [7:0] RST [4] = '{8'h00, 8'h00, 8'h07, 8'h00};
    localparam logic [7:0] RXC [8] = '{8'h64, 8'h64, 8'h82, 8'h82, 8'h82, 8'h82, 8'h82, 8'h82};
    localparam logic [8:0] TXC [8] = '{9'h0, 9'h64, 9'h64, 9'h64, 9'h64, 9'hC8, 9'h12C, 9'h12C};
    localparam logic [7:0] CLR [8] = '{8'h00, 8'h00, 8'h00, 8'h60, 8'h10, 8'h00, 8'h00, 8'h04};
    localparam logic [7:0] EXP [8] = '{8'h40, 8'h60, 8'h70, 8'h10, 8'h10, 8'h18, 8'h1C, 8'h1C};
    logic clock = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, bus_idle = 1'b0;
    logic rx_overrun = 1'b0, rx_msg_ready = 1'b0, sleep_mode = 1'b0, bus_activity = 1'b0;
    logic rx_swap, bus_off_state, recessive_run_seen, wake_irq, error_irq, rx_irq, tx_irq;
    logic [8:0] reg_addr = 9'h000, tx_error_count = 9'h000;
    logic [7:0] reg_wdata = 8'h00, rx_error_count = 8'h00, reg_rdata;
    logic [2:0] start = 3'h0, finish = 3'h0, fail = 3'h0;
    logic [2:0] tx_active, tx_sent_ok, tx_buffer_empty, abort_request;
    int n_mismatch = 0, check_count = 0, n_swap = 0, cycles = 0, i;
    can_flag_and_tx_handshake uut (
        .clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .rx_error_count, .tx_error_count, .recessive_run_seen, .sleep_mode, .bus_activity,
        .rx_overrun, .rx_msg_ready, .rx_swap, .tx_sent_ok, .tx_active, .tx_buffer_empty,
        .abort_request, .bus_off_state, .wake_irq, .error_irq, .rx_irq, .tx_irq
    );
    can_engine_model engine (
        .clock, .resetn, .start, .finish, .fail, .bus_idle, .tx_buffer_empty, .tx_active,
        .tx_sent_ok, .recessive_run_seen
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        chk(reg_rdata, exp);
    endtask
    task automatic eng(input logic [2:0] s, input logic [2:0] f, input logic [2:0] x);
        @(posedge clock);
        start <= s;
        finish <= f;
        fail <= x;
        @(posedge clock);
        {start, finish, fail} <= 9'h000;
    endtask
    task automatic final_report;
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial forever #20 clock = ~clock;
    // Counts swap pulses and cuts a hung run short.
    always @(negedge clock) begin
        if (rx_swap === 1'b1) n_swap++;
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report;
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        for (i = 0; i < 4; i++) rd(9'h104 + 9'(i), RST[i]);
        rd(9'h1FF, 8'h00);
        wr(9'h107, 8'h01);
        @(negedge clock);
        chk(8'(tx_irq), 8'h01);
        wr(9'h106, 8'h01);
        @(negedge clock);
        chk(8'(tx_irq), 8'h00);
        chk(8'(tx_buffer_empty), 8'h06);
        eng(3'h1, 3'h0, 3'h0);
        wr(9'h107, 8'h11);
        wr(9'h107, 8'h01);
        @(negedge clock);
        chk(8'(abort_request), 8'h01);
        chk(8'(tx_buffer_empty), 8'h06);
        eng(3'h0, 3'h0, 3'h1);
        rd(9'h106, 8'h17);
        chk(8'(abort_request), 8'h00);
        chk(8'(tx_irq), 8'h01);
        wr(9'h106, 8'h70);
        rd(9'h106, 8'h17);
        wr(9'h106, 8'h01);
        rd(9'h106, 8'h06);
        eng(3'h1, 3'h0, 3'h0);
        eng(3'h0, 3'h1, 3'h0);
        rd(9'h106, 8'h07);
        wr(9'h105, 8'hFF);
        for (i = 0; i < 8; i++) begin
            @(posedge clock);
            rx_error_count <= RXC[i];
            tx_error_count <= TXC[i];
            if (CLR[i] != 8'h00) wr(9'h104, CLR[i]);
            rd(9'h104, EXP[i]);
        end
        chk(8'(error_irq), 8'h01);
        rd(9'h108, 8'h01);
        @(posedge clock);
        tx_error_count <= 9'h000;
        rx_error_count <= 8'h00;
        bus_idle <= 1'b1;
        for (i = 0; i < 2000 && bus_off_state !== 1'b0; i++) @(posedge clock);
        bus_idle <= 1'b0;
        chk(8'(bus_off_state), 8'h00);
        wr(9'h104, 8'hFF);
        rd(9'h104, 8'h00);
        chk(8'(error_irq), 8'h00);
        @(posedge clock);
        rx_overrun <= 1'b1;
        @(posedge clock);
        rx_overrun <= 1'b0;
        rd(9'h104, 8'h02);
        chk(8'(error_irq), 8'h01);
        wr(9'h105, 8'hFD);
        @(negedge clock);
        chk(8'(error_irq), 8'h00);
        wr(9'h104, 8'h02);
        @(posedge clock);
        rx_msg_ready <= 1'b1;
        repeat (6) @(posedge clock);
        chk(8'(n_swap), 8'h01);
        chk(8'(rx_irq), 8'h01);
        wr(9'h104, 8'h01);
        repeat (3) @(posedge clock);
        rx_msg_ready <= 1'b0;
        chk(8'(n_swap), 8'h02);
        @(posedge clock);
        sleep_mode <= 1'b1;
        bus_activity <= 1'b1;
        @(posedge clock);
        {sleep_mode, bus_activity} <= 2'h0;
        rd(9'h104, 8'h81);
        chk(8'(wake_irq), 8'h01);
        wr(9'h100, 8'h01);
        @(negedge clock);
        chk(8'(wake_irq), 8'h00);
        wr(9'h105, 8'hFF);
        rd(9'h105, 8'h00);
        rd(9'h104, 8'h00);
        wr(9'h100, 8'h00);
        final_report;
    end
endmodule
bind can_flag_and_tx_handshake can_flag_chk checks (
    .clock, .resetn, .reg_write, .tx_error_count, .recessive_run_seen, .rx_msg_ready,
    .tx_sent_ok, .tx_active, .rx_swap, .tx_buffer_empty, .abort_request, .bus_off_state, .tx_irq
);
`default_nettype wire
